// ### design/amp_control_pkg.sv
package amp_control_pkg;

    // ==========================================================
    // register map
    localparam logic [31:0] BASE_ADDRESS_DEFAULT = 32'h4801_8000;
    localparam logic [31:0] CTRL_OFFSET          = 32'h0000_0000;
    localparam logic [31:0] CTRL_RESET           = 32'h0000_0000;
    localparam logic [31:0] CTRL_WRITE_MASK      = 32'h0000_0107;
    localparam logic [3:0]  FULL_WORD_SEL        = 4'hf;

    // ==========================================================
    // field positions
    localparam int POWER_BIT  = 0;
    localparam int GAIN_LSB   = 1;
    localparam int GAIN_MSB   = 2;
    localparam int SOURCE_BIT = 8;

    // ==========================================================
    // gain encodings and factors
    typedef enum logic [1:0] {
        GAIN_10 = 2'b00,
        GAIN_20 = 2'b01,
        GAIN_40 = 2'b10,
        GAIN_60 = 2'b11
    } gain_e;

    localparam logic [5:0] FACTOR_10 = 6'h0a;
    localparam logic [5:0] FACTOR_20 = 6'h14;
    localparam logic [5:0] FACTOR_40 = 6'h28;
    localparam logic [5:0] FACTOR_60 = 6'h3c;

    // ==========================================================
    // signals driven into the analog amplifier
    typedef struct packed {
        logic       amp_power_on;
        gain_e      amp_gain_select;
        logic [5:0] amp_gain_factor;
        logic       adc_source_select;
        logic       amp_output_route;
        logic       zero_reference_route;
    } amp_drive_s;

    function automatic logic [5:0] gain_factor(input gain_e code);
        case (code)
            GAIN_10: gain_factor = FACTOR_10;
            GAIN_20: gain_factor = FACTOR_20;
            GAIN_40: gain_factor = FACTOR_40;
            GAIN_60: gain_factor = FACTOR_60;
            default: gain_factor = FACTOR_10;
        endcase
    endfunction : gain_factor

endpackage : amp_control_pkg

// ### design/wb_access_check.sv
`timescale 1ns/100ps

// ==========================================================
// classifies one bus access against the single control word
module wb_access_check #(
    parameter logic [31:0] BASE_ADDRESS = amp_control_pkg::BASE_ADDRESS_DEFAULT
) (
    // bus request
    input  wire logic [31:0] adr_i,
    input  wire logic [3:0]  sel_i,
    // classification
    output logic             hit,
    output logic             whole_word
);

    always_comb
    begin
        hit        = (adr_i == BASE_ADDRESS + amp_control_pkg::CTRL_OFFSET);
        whole_word = (sel_i == amp_control_pkg::FULL_WORD_SEL);
    end

endmodule : wb_access_check

// ### design/amp_control_status.sv
//==========================================================
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/100ps

module amp_control_status #(
    parameter logic [31:0] BASE_ADDRESS = amp_control_pkg::BASE_ADDRESS_DEFAULT
) (
    // clock and reset
    input  wire logic                         clock,
    input  wire logic                         global_system_reset_n,
    // classic wishbone slave
    input  wire logic                         cyc_i,
    input  wire logic                         stb_i,
    input  wire logic                         we_i,
    input  wire logic [31:0]                  adr_i,
    input  wire logic [3:0]                   sel_i,
    input  wire logic [31:0]                  dat_i,
    output logic [31:0]                       dat_o,
    output logic                              ack_o,
    output logic                              err_o,
    // amplifier drive
    output amp_control_pkg::amp_drive_s       amp_drive
);

    // ==========================================================
    // state
    typedef struct packed {
        logic                        power;
        amp_control_pkg::gain_e      gain;
        logic                        source;
        logic                        ack;
        logic                        err;
        logic [31:0]                 dat;
        amp_control_pkg::amp_drive_s drive;
    } state_s;

    state_s state_r;
    state_s state_nxt;
    logic   hit;
    logic   whole_word;
    logic   request;
    logic   accept;
    logic   write_take;

    wb_access_check #(
        .BASE_ADDRESS (BASE_ADDRESS)
    ) i_wb_access_check (
        .adr_i      (adr_i),
        .sel_i      (sel_i),
        .hit        (hit),
        .whole_word (whole_word)
    );

    function automatic logic [31:0] ctrl_word(input state_s s);
        logic [31:0] w;
        w = amp_control_pkg::CTRL_RESET;
        w[amp_control_pkg::POWER_BIT]                          = s.power;
        w[amp_control_pkg::GAIN_MSB:amp_control_pkg::GAIN_LSB] = s.gain;
        w[amp_control_pkg::SOURCE_BIT]                         = s.source;
        ctrl_word = w;
    endfunction : ctrl_word

    // ==========================================================
    // bus decode: one answer per request, ack or err one cycle later
    always_comb
    begin
        request    = cyc_i && stb_i && !state_r.ack && !state_r.err;
        accept     = request && hit && whole_word;
        write_take = accept && we_i;
    end

    // ==========================================================
    // next state
    always_comb
    begin
        state_nxt     = state_r;
        state_nxt.ack = accept;
        state_nxt.err = request && !accept;
        state_nxt.dat = amp_control_pkg::CTRL_RESET;
        if (write_take)
        begin
            // reserved positions are simply not stored
            state_nxt.power  = dat_i[amp_control_pkg::POWER_BIT];
            state_nxt.gain   = amp_control_pkg::gain_e'(dat_i[amp_control_pkg::GAIN_MSB:amp_control_pkg::GAIN_LSB]);
            state_nxt.source = dat_i[amp_control_pkg::SOURCE_BIT];
        end
        if (accept && !we_i)
        begin
            state_nxt.dat = ctrl_word(state_r) & amp_control_pkg::CTRL_WRITE_MASK;
        end
        state_nxt.drive.amp_power_on         = state_nxt.power;
        state_nxt.drive.amp_gain_select      = state_nxt.gain;
        state_nxt.drive.amp_gain_factor      = amp_control_pkg::gain_factor(state_nxt.gain);
        state_nxt.drive.adc_source_select    = state_nxt.source;
        state_nxt.drive.amp_output_route     = !state_nxt.source;
        state_nxt.drive.zero_reference_route = state_nxt.source;
    end

    // ==========================================================
    // state register
    always_ff @(posedge clock or negedge global_system_reset_n)
    begin
        if (!global_system_reset_n)
        begin
            state_r                            <= '0;
            state_r.drive.amp_gain_factor      <= amp_control_pkg::FACTOR_10;
            state_r.drive.amp_output_route     <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    always_comb
    begin
        dat_o     = state_r.dat;
        ack_o     = state_r.ack;
        err_o     = state_r.err;
        amp_drive = state_r.drive;
    end

    // ==========================================================
    // assertions
    property p_power_write;
        @(posedge clock) disable iff (!global_system_reset_n)
        write_take |=> ack_o && (amp_drive.amp_power_on == $past(dat_i[amp_control_pkg::POWER_BIT]));
    endproperty
    a_power_write: assert property (p_power_write) else $error("power bit did not follow write");

    property p_gain_write;
        @(posedge clock) disable iff (!global_system_reset_n)
        write_take |=> amp_drive.amp_gain_select == $past(dat_i[amp_control_pkg::GAIN_MSB:amp_control_pkg::GAIN_LSB]);
    endproperty
    a_gain_write: assert property (p_gain_write) else $error("gain code did not follow write");

    property p_gain_factor;
        @(posedge clock) disable iff (!global_system_reset_n)
        (amp_drive.amp_gain_select != amp_control_pkg::GAIN_10
            || amp_drive.amp_gain_factor == amp_control_pkg::FACTOR_10)
        && (amp_drive.amp_gain_select != amp_control_pkg::GAIN_20
            || amp_drive.amp_gain_factor == amp_control_pkg::FACTOR_20)
        && (amp_drive.amp_gain_select != amp_control_pkg::GAIN_40
            || amp_drive.amp_gain_factor == amp_control_pkg::FACTOR_40)
        && (amp_drive.amp_gain_select != amp_control_pkg::GAIN_60
            || amp_drive.amp_gain_factor == amp_control_pkg::FACTOR_60);
    endproperty
    a_gain_factor: assert property (p_gain_factor) else $error("gain factor mismatches code");

    property p_route;
        @(posedge clock) disable iff (!global_system_reset_n)
        write_take |=> (amp_drive.zero_reference_route == $past(dat_i[amp_control_pkg::SOURCE_BIT]))
                       && (amp_drive.amp_output_route != amp_drive.zero_reference_route);
    endproperty
    a_route: assert property (p_route) else $error("adc routing wrong after write");

    property p_reset_clear;
        @(posedge clock)
        !global_system_reset_n |-> (ctrl_word(state_r) == amp_control_pkg::CTRL_RESET)
                                   && amp_drive.amp_output_route && !ack_o && !err_o;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("register not cleared by reset");

    property p_partial_refused;
        @(posedge clock) disable iff (!global_system_reset_n)
        (request && !whole_word) |=> err_o && !ack_o && $stable(amp_drive);
    endproperty
    a_partial_refused: assert property (p_partial_refused) else $error("partial word access not refused");

    property p_outside_refused;
        @(posedge clock) disable iff (!global_system_reset_n)
        (request && !hit) |=> err_o && $stable(amp_drive);
    endproperty
    a_outside_refused: assert property (p_outside_refused) else $error("access outside base not refused");

    property p_change_needs_write;
        @(posedge clock) disable iff (!global_system_reset_n)
        $changed(ctrl_word(state_r)) |-> $past(write_take);
    endproperty
    a_change_needs_write: assert property (p_change_needs_write) else $error("register changed without write");

    property p_reserved_zero;
        @(posedge clock) disable iff (!global_system_reset_n)
        ack_o |-> ((dat_o & ~amp_control_pkg::CTRL_WRITE_MASK) == 32'h0000_0000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read non-zero");

    property p_single_answer;
        @(posedge clock) disable iff (!global_system_reset_n)
        (ack_o || err_o) |=> !ack_o && !err_o;
    endproperty
    a_single_answer: assert property (p_single_answer) else $error("answer held longer than one cycle");

    property p_cover_write;
        @(posedge clock) disable iff (!global_system_reset_n)
        write_take ##1 ack_o;
    endproperty
    c_cover_write: cover property (p_cover_write);

    property p_cover_read;
        @(posedge clock) disable iff (!global_system_reset_n)
        (accept && !we_i) ##1 ack_o;
    endproperty
    c_cover_read: cover property (p_cover_read);

    property p_cover_err;
        @(posedge clock) disable iff (!global_system_reset_n)
        err_o;
    endproperty
    c_cover_err: cover property (p_cover_err);

    property p_cover_gain60;
        @(posedge clock) disable iff (!global_system_reset_n)
        amp_drive.amp_gain_factor == amp_control_pkg::FACTOR_60 && amp_drive.zero_reference_route;
    endproperty
    c_cover_gain60: cover property (p_cover_gain60);

endmodule : amp_control_status

// ### test/tb_top.sv
`timescale 1ns/100ps

module tb_top;

    // ==========================================================
    // clock, reset and bus signals
    localparam logic [31:0] BASE = 32'h4801_8000;
    logic                        clock                 = 1'b0;
    logic                        global_system_reset_n = 1'b1;
    logic                        cyc_i                 = 1'b0;
    logic                        stb_i                 = 1'b0;
    logic                        we_i                  = 1'b0;
    logic [31:0]                 adr_i                 = 32'h0000_0000;
    logic [3:0]                  sel_i                 = 4'h0;
    logic [31:0]                 dat_i                 = 32'h0000_0000;
    logic [31:0]                 dat_o;
    logic                        ack_o;
    logic                        err_o;
    amp_control_pkg::amp_drive_s amp_drive;
    int                          miscompares           = 0;
    int                          compares              = 0;
    int                          cycles                = 0;
    logic [31:0]                 rd;
    logic                        er;

    always #5 clock = ~clock;

    amp_control_status #(.BASE_ADDRESS(BASE)) i_amp_control_status (
        .clock                 (clock),
        .global_system_reset_n (global_system_reset_n),
        .cyc_i                 (cyc_i),
        .stb_i                 (stb_i),
        .we_i                  (we_i),
        .adr_i                 (adr_i),
        .sel_i                 (sel_i),
        .dat_i                 (dat_i),
        .dat_o                 (dat_o),
        .ack_o                 (ack_o),
        .err_o                 (err_o),
        .amp_drive             (amp_drive)
    );

    // ==========================================================
    // report and compare tasks
    task automatic close_out;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t word got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t error flag got %b expected %b", $time, got, exp);
        end
    endtask : chk_flag

    // expected drive worked out from the control word
    task automatic chk_drive(input logic [31:0] w);
        amp_control_pkg::amp_drive_s e;
        logic [5:0]                  f [4];
        f                      = '{6'h0a, 6'h14, 6'h28, 6'h3c};
        e.amp_power_on         = w[0];
        e.amp_gain_select      = amp_control_pkg::gain_e'(w[2:1]);
        e.amp_gain_factor      = f[w[2:1]];
        e.adc_source_select    = w[8];
        e.amp_output_route     = ~w[8];
        e.zero_reference_route = w[8];
        compares++;
        if (amp_drive !== e)
        begin
            miscompares++;
            $display("[ERR] %0t drive got %h expected %h", $time, amp_drive, e);
        end
    endtask : chk_drive

    // ==========================================================
    // classic wishbone single cycle
    task automatic bus(input logic w, input logic [31:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge clock);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        do
        begin
            @(posedge clock);
        end
        while (ack_o !== 1'b1 && err_o !== 1'b1);
        rd = dat_o;
        er = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask : bus

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            $display("[ERR] %0t run did not finish", $time);
            close_out();
        end
    end

    // ==========================================================
    // main sequence
    initial
    begin
        logic [31:0] d;
        global_system_reset_n <= 1'b0;
        repeat (5) @(posedge clock);
        global_system_reset_n <= 1'b1;
        @(posedge clock);
        chk_drive(32'h0000_0000);
        bus(1'b0, BASE, 4'hf, 32'h0000_0000);
        chk_word(rd, 32'h0000_0000);
        // every gain code, both power and source levels, reserved bits set
        for (int i = 0; i < 4; i++)
        begin
            d = 32'hffff_fef8 | {23'd0, i[0], 5'd0, i[1:0], ~i[0]};
            bus(1'b1, BASE, 4'hf, d);
            chk_flag(er, 1'b0);
            chk_drive(d);
            bus(1'b0, BASE, 4'hf, 32'h0000_0000);
            chk_word(rd, d & 32'h0000_0107);
        end
        bus(1'b1, BASE, 4'hf, 32'h0000_0107);
        // refused accesses leave the word untouched
        bus(1'b1, BASE + 32'h0000_0004, 4'hf, 32'h0000_0000);
        chk_flag(er, 1'b1);
        bus(1'b1, BASE + 32'h0001_0000, 4'hf, 32'h0000_0000);
        chk_flag(er, 1'b1);
        bus(1'b1, BASE, 4'h3, 32'h0000_0000);
        chk_flag(er, 1'b1);
        bus(1'b0, BASE, 4'h1, 32'h0000_0000);
        chk_flag(er, 1'b1);
        chk_word(rd, 32'h0000_0000);
        chk_drive(32'h0000_0107);
        bus(1'b0, BASE, 4'hf, 32'h0000_0000);
        chk_word(rd, 32'h0000_0107);
        // reset in mid-run acts before the next clock edge
        @(posedge clock);
        global_system_reset_n <= 1'b0;
        #1;
        chk_drive(32'h0000_0000);
        repeat (2) @(posedge clock);
        global_system_reset_n <= 1'b1;
        bus(1'b0, BASE, 4'hf, 32'h0000_0000);
        chk_word(rd, 32'h0000_0000);
        repeat (2) @(posedge clock);
        close_out();
    end

endmodule : tb_top
